// >>> design/ext_mem_cfg_pkg.sv
// Purpose: constants for the external memory configuration decoder
// Assumes: two configuration bytes presented while reset is asserted
// Notes: bit positions, reset values and timing counts
package ext_mem_cfg_pkg;
	// byte zero fields
	localparam int unsigned CFG0_SRC_BIT       = 0;
	localparam int unsigned CFG0_PAGE_BIT      = 1;
	localparam int unsigned CFG0_SEL_LO_BIT    = 2;
	localparam int unsigned CFG0_SEL_HI_BIT    = 3;
	localparam int unsigned CFG0_LATCH_BIT     = 4;
	localparam int unsigned CFG0_OTHER_WAIT_BIT = 5;
	// byte one fields
	localparam int unsigned CFG1_MIRROR_BIT    = 0;
	localparam int unsigned CFG1_R01_WAIT_BIT  = 3;
	localparam int unsigned CFG1_STACK_BIT     = 4;
	localparam logic [7:0]  CFG1_RSVD_MASK     = 8'he6;
	// erased configuration reads all ones
	localparam logic [7:0]  CFG_RESET_VALUE    = 8'hff;
	// memory signal select codes
	localparam logic [1:0]  SEL_ADDR18         = 2'h0;
	localparam logic [1:0]  SEL_ADDR17         = 2'h1;
	localparam logic [1:0]  SEL_ADDR16         = 2'h2;
	localparam logic [1:0]  SEL_SPLIT          = 2'h3;
	// regions
	localparam logic [7:0]  REGION_00          = 8'h00;
	localparam logic [7:0]  REGION_01          = 8'h01;
	localparam logic [7:0]  REGION_FE          = 8'hfe;
	localparam logic [7:0]  REGION_FF          = 8'hff;
	// mirrored window: data 00:e000-00:ffff from code ff:2000-ff:3fff
	localparam logic [2:0]  MIRROR_DATA_TOP    = 3'h7;
	localparam logic [2:0]  MIRROR_CODE_TOP    = 3'h1;
	// timing
	localparam int unsigned CLKS_PER_STATE     = 2;
	localparam logic [1:0]  CLKS_PER_STATE_W   = 2'h2;
	localparam logic [2:0]  LATCH_LONG_OSC     = 3'h3;
	localparam logic [2:0]  LATCH_SHORT_OSC    = 3'h1;
	localparam logic [2:0]  STACK_BYTES_SHORT  = 3'h2;
	localparam logic [2:0]  STACK_BYTES_LONG   = 3'h4;
	localparam logic [2:0]  ACCESS_BASE_STATES = 3'h2;
	localparam logic [2:0]  FETCH_PAGE_STATES  = 3'h1;
	localparam logic [2:0]  FETCH_NONPAGE_BASE = 3'h2;
	localparam int unsigned QUEUE_DEPTH        = 4;
endpackage

// >>> design/ext_memory_config_decoder.sv
// Purpose: decode configuration bytes into memory interface and core settings
// Assumes: bytes stable while rst_b low; inputs synchronous to sys_clk
// Notes: settings frozen from reset release until the next reset
`timescale 1ns/10ps
module ext_memory_config_decoder (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] config_byte_zero,
	input  wire logic [7:0] config_byte_one,
	input  wire logic       external_access_n,
	input  wire logic [7:0] access_region,
	input  wire logic [15:0] access_offset,
	input  wire logic       access_is_code,
	input  wire logic       access_is_write,
	input  wire logic       access_is_word,
	input  wire logic       code_on_chip,
	input  wire logic       queue_push,
	input  wire logic       queue_pop,
	output logic            addr_bit17_on_p17,
	output logic            addr_bit16_on_p37,
	output logic            p37_is_read_strobe,
	output logic            use_program_store_strobe_n,
	output logic            use_write_strobe,
	output logic            page_mode,
	output logic            p2_mux_data,
	output logic            p0_mux_data,
	output logic            source_mode,
	output logic [2:0]      interrupt_push_bytes,
	output logic [2:0]      return_pop_bytes,
	output logic            wait_state,
	output logic            code_mirror_hit,
	output logic [2:0]      latch_pulse_osc,
	output logic            state_tick,
	output logic [4:0]      fetch_width,
	output logic [2:0]      fetch_states_per_byte,
	output logic [2:0]      operand_extra_states,
	output logic            config_reserved_bad,
	output logic [2:0]      queue_level,
	output logic            queue_full
);
	import ext_mem_cfg_pkg::*;

	logic [7:0] cfg0_r;
	logic [7:0] cfg1_r;
	logic [1:0] mem_signal_select;
	logic       mem_signal_select_hi;
	logic       mem_signal_select_lo;
	logic       interrupt_stack_width;
	logic       region01_wait_n;
	logic       other_region_wait_n;
	logic       latch_pulse_extend_n;
	logic       code_mirror_disable;
	logic       wait_nxt;
	logic [2:0] byte_extra;
	logic [1:0] clk_cnt_r;
	logic [2:0] queue_level_nxt;

	// pins sampled only while held in reset; access pin deliberately unused
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfg0_r <= config_byte_zero;
			cfg1_r <= config_byte_one;
		end
	end

	assign mem_signal_select_hi  = cfg0_r[CFG0_SEL_HI_BIT];
	assign mem_signal_select_lo  = cfg0_r[CFG0_SEL_LO_BIT];
	assign mem_signal_select     = {mem_signal_select_hi, mem_signal_select_lo};
	assign latch_pulse_extend_n  = cfg0_r[CFG0_LATCH_BIT];
	assign other_region_wait_n   = cfg0_r[CFG0_OTHER_WAIT_BIT];
	assign code_mirror_disable   = cfg1_r[CFG1_MIRROR_BIT];
	assign region01_wait_n       = cfg1_r[CFG1_R01_WAIT_BIT];
	assign interrupt_stack_width = cfg1_r[CFG1_STACK_BIT];

	// strobe and address pin roles
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			addr_bit17_on_p17          <= 1'b0;
			addr_bit16_on_p37          <= 1'b0;
			p37_is_read_strobe         <= 1'b0;
			use_program_store_strobe_n <= 1'b0;
			use_write_strobe           <= 1'b0;
		end else begin
			addr_bit17_on_p17  <= (mem_signal_select == SEL_ADDR18);
			addr_bit16_on_p37  <= (mem_signal_select == SEL_ADDR18) ||
			                      (mem_signal_select == SEL_ADDR17);
			use_write_strobe   <= access_is_write;
			p37_is_read_strobe <= 1'b0;
			use_program_store_strobe_n <= 1'b0;
			if (!access_is_write) begin
				if (mem_signal_select == SEL_SPLIT) begin
					// data regions read with port 3.7, code regions with store strobe
					p37_is_read_strobe <= (access_region == REGION_00) ||
					                      (access_region == REGION_01);
					use_program_store_strobe_n <= (access_region == REGION_FE) ||
					                              (access_region == REGION_FF);
				end else begin
					use_program_store_strobe_n <= 1'b1;
				end
			end
		end
	end

	// port multiplexing and core modes
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			page_mode            <= 1'b0;
			p2_mux_data          <= 1'b0;
			p0_mux_data          <= 1'b0;
			source_mode          <= 1'b0;
			interrupt_push_bytes <= STACK_BYTES_SHORT;
			return_pop_bytes     <= STACK_BYTES_SHORT;
			latch_pulse_osc      <= LATCH_SHORT_OSC;
			config_reserved_bad  <= 1'b0;
		end else begin
			page_mode   <= !cfg0_r[CFG0_PAGE_BIT];
			p2_mux_data <= !cfg0_r[CFG0_PAGE_BIT];
			p0_mux_data <= cfg0_r[CFG0_PAGE_BIT];
			source_mode <= cfg0_r[CFG0_SRC_BIT];
			// the pop count tracks the push count, so frames always balance
			interrupt_push_bytes <= interrupt_stack_width ? STACK_BYTES_LONG : STACK_BYTES_SHORT;
			return_pop_bytes     <= interrupt_stack_width ? STACK_BYTES_LONG : STACK_BYTES_SHORT;
			latch_pulse_osc <= latch_pulse_extend_n ? LATCH_SHORT_OSC : LATCH_LONG_OSC;
			// flags a reserved bit cleared to zero, nothing else depends on it
			config_reserved_bad <= ((cfg1_r & CFG1_RSVD_MASK) != CFG1_RSVD_MASK);
		end
	end

	// wait states per region
	always_comb begin
		if (access_region == REGION_01) begin
			wait_nxt = !region01_wait_n;
		end else begin
			wait_nxt = !other_region_wait_n;
		end
	end

	assign byte_extra = ACCESS_BASE_STATES + {2'h0, wait_nxt};

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			wait_state            <= 1'b0;
			code_mirror_hit       <= 1'b0;
			fetch_width           <= 5'h08;
			fetch_states_per_byte <= FETCH_PAGE_STATES;
			operand_extra_states  <= ACCESS_BASE_STATES;
		end else begin
			wait_state <= wait_nxt;
			code_mirror_hit <= !code_mirror_disable && !access_is_code &&
			                   (access_region == REGION_00) &&
			                   (access_offset[15:13] == MIRROR_DATA_TOP);
			fetch_width <= code_on_chip ? 5'h10 : 5'h08;
			if (cfg0_r[CFG0_PAGE_BIT]) begin
				fetch_states_per_byte <= FETCH_NONPAGE_BASE + {2'h0, wait_nxt};
			end else begin
				fetch_states_per_byte <= FETCH_PAGE_STATES;
			end
			operand_extra_states <= access_is_word ? 3'(byte_extra << 1) : byte_extra;
		end
	end

	// state tick every two clocks
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			clk_cnt_r  <= 2'h0;
			state_tick <= 1'b0;
		end else begin
			if (clk_cnt_r == CLKS_PER_STATE_W - 2'h1) begin
				clk_cnt_r  <= 2'h0;
				state_tick <= 1'b1;
			end else begin
				clk_cnt_r  <= clk_cnt_r + 2'h1;
				state_tick <= 1'b0;
			end
		end
	end

	// prefetch occupancy, only meaningful for external code
	always_comb begin
		queue_level_nxt = queue_level;
		if (!code_on_chip) begin
			if (queue_push && !queue_full && !(queue_pop && queue_level != 3'h0)) begin
				queue_level_nxt = queue_level + 3'h1;
			end else if (queue_pop && queue_level != 3'h0 && !(queue_push && !queue_full)) begin
				queue_level_nxt = queue_level - 3'h1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			queue_level <= 3'h0;
			queue_full  <= 1'b0;
		end else begin
			queue_level <= queue_level_nxt;
			queue_full  <= (queue_level_nxt == 3'(QUEUE_DEPTH));
		end
	end
endmodule

// >>> testbench/ext_cfg_checker_sva.sv
// Purpose: port relations of the configuration decoder
// Assumes: outputs registered one edge after their inputs
// Notes: bound from the test top
`timescale 1ns/10ps
module ext_cfg_checker (
	input wire logic	sys_clk,
	input wire logic	rst_b,
	input wire logic [7:0]	access_region,
	input wire logic	access_is_code,
	input wire logic	access_is_word,
	input wire logic	code_on_chip,
	input wire logic	addr_bit16_on_p37,
	input wire logic	p37_is_read_strobe,
	input wire logic	use_program_store_strobe_n,
	input wire logic	page_mode,
	input wire logic	p2_mux_data,
	input wire logic	p0_mux_data,
	input wire logic	source_mode,
	input wire logic [2:0]	interrupt_push_bytes,
	input wire logic [2:0]	return_pop_bytes,
	input wire logic	wait_state,
	input wire logic	code_mirror_hit,
	input wire logic [2:0]	latch_pulse_osc,
	input wire logic	state_tick,
	input wire logic [4:0]	fetch_width,
	input wire logic [2:0]	fetch_states_per_byte,
	input wire logic [2:0]	operand_extra_states,
	input wire logic [2:0]	queue_level,
	input wire logic	queue_full
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_tick_gap;
		!state_tick ##1 state_tick;
	endsequence
	a_tick_period: assert property (state_tick |=> s_tick_gap) else $error("state tick spacing wrong");
	a_pop_match: assert property (return_pop_bytes == interrupt_push_bytes) else $error("pop count differs");
	a_extra_states: assert property ($past(rst_b) |-> operand_extra_states ==
		(($past(access_is_word) ? 3'h2 : 3'h1) * (3'h2 + {2'h0, wait_state}))) else $error("operand states wrong");
	a_fetch_rate: assert property ($past(rst_b) |-> fetch_states_per_byte ==
		(page_mode ? 3'h1 : 3'h2 + {2'h0, wait_state})) else $error("fetch states wrong");
	a_fetch_width: assert property ($past(rst_b) |-> fetch_width ==
		($past(code_on_chip) ? 5'h10 : 5'h08)) else $error("fetch width wrong");
	a_port_mux: assert property ($past(rst_b) |-> p0_mux_data != p2_mux_data && page_mode == p2_mux_data)
		else $error("port multiplexing wrong");
	a_config_held: assert property ($past(rst_b) && $past(rst_b, 2) |-> $stable(source_mode) &&
		$stable(page_mode) && $stable(latch_pulse_osc)) else $error("setting changed after reset");
	a_mirror_cause: assert property (code_mirror_hit |-> !$past(access_is_code) &&
		$past(access_region) == 8'h00) else $error("mirror hit without cause");
	a_split_read: assert property (p37_is_read_strobe |-> !use_program_store_strobe_n &&
		!addr_bit16_on_p37) else $error("split read strobes clash");
	a_queue_full: assert property (queue_full == (queue_level == 3'h4)) else $error("queue full flag wrong");
endmodule

// >>> testbench/ext_mem_model.sv
// Purpose: external code memory delivering prefetch bytes
// Assumes: fetch_en high while code runs off chip
// Notes: one byte every 2 clocks, every 4 with a wait state
`timescale 1ns/10ps
module ext_mem_model (
	input wire logic	sys_clk,
	input wire logic	fetch_en,
	input wire logic	wait_state,
	output logic		queue_push
);
	logic [1:0]	gap_r = 2'h0;
	initial queue_push = 1'b0;
	// plain always: the power-up values above need a second writer
	always @(posedge sys_clk) begin
		gap_r <= gap_r + 2'h1;
		queue_push <= fetch_en && gap_r[0] && (gap_r[1] || !wait_state);
	end
endmodule

// >>> testbench/test_ext_memory_config_decoder.sv
// Purpose: directed test of the configuration decoder
// Assumes: inputs change at the falling edge
// Notes: fields checked against their bit meanings
`timescale 1ns/10ps
module test_ext_memory_config_decoder;
	logic		sys_clk, rst_b, external_access_n, access_is_code, access_is_write, access_is_word;
	logic		code_on_chip, queue_push, queue_pop, fetch_en, addr_bit17_on_p17, addr_bit16_on_p37;
	logic		p37_is_read_strobe, use_program_store_strobe_n, use_write_strobe, page_mode, p2_mux_data;
	logic		p0_mux_data, source_mode, wait_state, code_mirror_hit, state_tick, config_reserved_bad, queue_full;
	logic [7:0]	config_byte_zero, config_byte_one, access_region;
	logic [15:0]	access_offset;
	logic [2:0]	interrupt_push_bytes, return_pop_bytes, latch_pulse_osc, fetch_states_per_byte;
	logic [2:0]	operand_extra_states, queue_level;
	logic [4:0]	fetch_width;
	int		fail_count, checked, k;
	ext_memory_config_decoder ext_memory_config_decoder_inst (.*);
	ext_mem_model ext_mem_model_inst (.sys_clk, .fetch_en, .wait_state, .queue_push);
	initial begin
		sys_clk = 0;
		forever #25 sys_clk = ~sys_clk;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checked=%0d fail_count=%0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task boot(input logic [7:0] c0, input logic [7:0] c1);
		@(negedge sys_clk);
		rst_b = 0;
		config_byte_zero = c0;
		config_byte_one = c1;
		external_access_n = ~external_access_n;
		repeat (3) @(negedge sys_clk);
		rst_b = 1;
		// flipped bytes after release must change nothing
		config_byte_zero = ~c0;
		config_byte_one = ~c1;
	endtask
	task acc(input logic [7:0] rg, input logic [15:0] off, input logic cd, input logic wr, input logic wd);
		access_region = rg;
		access_offset = off;
		access_is_code = cd;
		access_is_write = wr;
		access_is_word = wd;
		@(negedge sys_clk);
	endtask
	initial begin
		{rst_b, external_access_n, access_is_code, access_is_write, access_is_word} = 0;
		{code_on_chip, queue_pop, fetch_en, access_region, access_offset} = 0;
		{config_byte_zero, config_byte_one} = 16'hffff;
		fail_count = 0;
		checked = 0;
		for (k = 0; k < 4; k++) begin
			code_on_chip = k[0];
			boot({2'h3, k[1], k[1], k[1:0], k[0], k[1]}, {3'h7, k[0], k[0], 2'h3, k[0]});
			acc(8'h00, 16'he000, 0, 0, 0);
			chk(config_reserved_bad, 0);
			chk(source_mode, k[1]);
			chk(page_mode, !k[0]);
			chk(p0_mux_data, k[0]);
			chk(interrupt_push_bytes, k[0] ? 4 : 2);
			chk(latch_pulse_osc, k[1] ? 1 : 3);
			chk(fetch_width, k[0] ? 16 : 8);
			chk(addr_bit17_on_p17, k == 0);
			chk(addr_bit16_on_p37, k < 2);
			chk(p37_is_read_strobe, k == 3);
			chk(use_program_store_strobe_n, k != 3);
			chk(code_mirror_hit, !k[0]);
			chk(wait_state, !k[1]);
			chk(fetch_states_per_byte, k[0] ? 2 + !k[1] : 1);
			chk(operand_extra_states, 2 + !k[1]);
			acc(8'h01, 16'h0000, 0, 1, 1);
			chk(wait_state, !k[0]);
			chk(operand_extra_states, 2 * (2 + !k[0]));
			chk(use_write_strobe, 1);
			chk(use_program_store_strobe_n, 0);
			acc(8'hfe, 16'h2000, 1, 0, 0);
			chk(use_program_store_strobe_n, 1);
			chk(code_mirror_hit, 0);
			$display("test config %0d done", k);
		end
		// queue fills to four and drains to zero while code runs off chip
		code_on_chip = 0;
		boot(8'hff, 8'h7f);
		acc(8'h00, 16'hdfff, 0, 0, 0);
		chk(config_reserved_bad, 1);
		chk(code_mirror_hit, 0);
		fetch_en = 1;
		repeat (20) @(negedge sys_clk);
		chk(queue_level, 4);
		chk(queue_full, 1);
		fetch_en = 0;
		queue_pop = 1;
		repeat (5) @(negedge sys_clk);
		queue_pop = 0;
		chk(queue_level, 0);
		$display("test queue done");
		report_and_stop;
	end
	initial begin
		#20000;
		fail_count++;
		report_and_stop;
	end
endmodule
bind ext_memory_config_decoder ext_cfg_checker ext_cfg_checker_inst (.*);
